/* verilog/hp_map.svh */
// host port constants: config offsets, field positions, port codes, timing counts
// assumes a 40 MHz system clock; included by bare name
`ifndef HP_MAP_SVH
`define HP_MAP_SVH

`define HP_CLK_PERIOD_NS 25
`define HP_PT_ASYNC16 8'h08
`define HP_PT_ASYNC8 8'h09
`define HP_CFG_FIRST_ADR 16'h0150
`define HP_CFG_LAST_ADR 16'h0153
`define HP_CFG_POL_ADR 16'h0150
`define HP_CFG_RDDLY_ADR 16'h0152
`define HP_ERR_CNT_ADR 16'h030d
`define HP_CFG_RESET 32'h0000_0000
// bit positions inside the polarity byte, 1 selects active high
`define HP_POL_CS 0
`define HP_POL_BHE 1
`define HP_POL_RD 2
`define HP_POL_WR 3
`define HP_POL_BUSY 4
`define HP_POL_IRQ 5
`define HP_RDDLY_BIT 0
`define HP_CNT_W 4
`define HP_ERR_MAX 8'hff
// times in ns
`define HP_RD_BYTE_NS 235
`define HP_RD_WORD_NS 315
`define HP_WR_BYTE_NS 200
`define HP_WR_WORD_NS 280
`define HP_RD_DLY_NS 20
`define HP_COLL_NS 20
// longest times round down, extra delays round up
`define HP_RD_BYTE_CYC (`HP_RD_BYTE_NS / `HP_CLK_PERIOD_NS)
`define HP_RD_WORD_CYC (`HP_RD_WORD_NS / `HP_CLK_PERIOD_NS)
`define HP_WR_BYTE_CYC (`HP_WR_BYTE_NS / `HP_CLK_PERIOD_NS)
`define HP_WR_WORD_CYC (`HP_WR_WORD_NS / `HP_CLK_PERIOD_NS)
`define HP_RD_DLY_CYC ((`HP_RD_DLY_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)
`define HP_COLL_CYC ((`HP_COLL_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)

`endif

/* verilog/hp_pkg.sv */
// host port types: normalised pin bundle, config bytes, internal access, states
// constants live in hp_map.svh
package hp_pkg;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic byte_high_enable_n;
    logic [15:0] adr;
    logic [15:0] data;
  } hp_pins_t;

  typedef struct packed {
    logic [7:0] b153;
    logic [7:0] b152;
    logic [7:0] b151;
    logic [7:0] b150;
  } hp_cfg_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] adr;
    logic [1:0] be;
    logic [15:0] wdata;
  } hp_mem_t;

  typedef enum logic [1:0] {
    HP_IDLE,
    HP_WRITE,
    HP_READ,
    HP_HOLD
  } hp_state_t;

endpackage

/* verilog/hp_pin_stage.sv */
// registers host pins and turns them into active-high form
// assumes pins synchronous to sys_clk_i
`timescale 1ns/1ps
`include "hp_map.svh"
module hp_pin_stage
  import hp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic en_i,
  input wire logic [7:0] pol_i,
  input wire logic [3:0] ctl_i,
  input wire logic [15:0] adr_i,
  input wire logic [15:0] data_i,
  output hp_pins_t pins_o
);

  logic [3:0] act;
  logic [3:0] pol;
  hp_pins_t pins_d;
  hp_pins_t pins_q;

  // ctl order: 3 cs, 2 rd, 1 wr, 0 bhe
  assign pol = {pol_i[`HP_POL_CS], pol_i[`HP_POL_RD], pol_i[`HP_POL_WR], pol_i[`HP_POL_BHE]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pol
      assign act[gi] = ctl_i[gi] ~^ pol[gi];
    end
  endgenerate

  always_comb begin
    pins_d = pins_q;
    // port disabled: strobes seen as idle
    pins_d.cs = act[3] & en_i;
    pins_d.rd = act[2] & en_i;
    pins_d.wr = act[1] & en_i;
    pins_d.byte_high_enable_n = act[0];
    pins_d.adr = adr_i;
    pins_d.data = data_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pins_q <= '0;
    end else if (clk_en_i) begin
      pins_q <= pins_d;
    end
  end

  assign pins_o = pins_q;

endmodule // hp_pin_stage

/* verilog/hp_err_cnt.sv */
// saturating access error counter
// inc and clr are one-cycle pulses
`timescale 1ns/1ps
`include "hp_map.svh"
module hp_err_cnt (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic inc_i,
  input wire logic clr_i,
  output logic [7:0] cnt_o
);

  logic [7:0] cnt_d;
  logic [7:0] cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    // an error in the clearing cycle still counts
    if (clr_i) begin
      cnt_d = inc_i ? 8'h01 : 8'h00;
    end else if (inc_i && cnt_q != `HP_ERR_MAX) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_q <= 8'h00;
    end else if (clk_en_i) begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt_o = cnt_q;

endmodule // hp_err_cnt

/* verilog/hp_async_port.sv */
// asynchronous 8/16 bit parallel host port, device end
// assumes host pins synchronous to sys_clk_i, internal memory answers in fixed time
`timescale 1ns/1ps
`include "hp_map.svh"
module hp_async_port
  import hp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] port_type_i,
  input hp_cfg_t cfg_i,
  input wire logic cfg_done_i,
  input wire logic cs_pin_i,
  input wire logic rd_pin_i,
  input wire logic wr_pin_i,
  input wire logic byte_high_enable_n_i,
  input wire logic [15:0] adr_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic [1:0] data_oe_o,
  output logic busy_o,
  output logic busy_oe_o,
  input wire logic irq_req_i,
  output logic irq_o,
  output logic irq_oe_o,
  output logic cfg_loaded_o,
  output logic cfg_loaded_oe_o,
  output hp_mem_t mem_o,
  input wire logic [15:0] mem_rdata_i,
  output logic abort_o,
  input wire logic err_clr_i,
  output logic [7:0] err_cnt_o
);

  logic en;
  logic wide;
  logic rd_dly;
  hp_pins_t p;
  logic wr_act;
  logic rd_act;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic rd_go;
  logic busy;
  logic err;
  logic [1:0] wbe;
  logic wvalid;
  logic [1:0] rbe;
  logic rvalid;
  logic coll;
  logic coll_adr;
  logic [`HP_CNT_W-1:0] rd_cyc;

  hp_state_t st_d, st_q;
  logic [`HP_CNT_W-1:0] cnt_d, cnt_q;
  logic wr_act_q, rd_act_q;
  logic rd_pend_d, rd_pend_q;
  logic [15:0] wadr_d, wadr_q;
  logic [15:0] wdat_d, wdat_q;
  logic wbhe_d, wbhe_q;
  logic [15:0] radr_d, radr_q;
  logic rbhe_d, rbhe_q;
  logic [15:0] lwadr_d, lwadr_q;
  logic [1:0] lwbe_d, lwbe_q;
  logic lw_d, lw_q;
  logic [15:0] rdata_d, rdata_q;
  hp_mem_t mem_d, mem_q;
  logic abort_d, abort_q;

  // port type select and options
  assign en = cfg_done_i & (port_type_i == `HP_PT_ASYNC16 || port_type_i == `HP_PT_ASYNC8);
  assign wide = port_type_i == `HP_PT_ASYNC16;
  assign rd_dly = cfg_i.b152[`HP_RDDLY_BIT];

  hp_pin_stage u_pins (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clk_en_i(clk_en_i),
    .en_i(en),
    .pol_i(cfg_i.b150),
    .ctl_i({cs_pin_i, rd_pin_i, wr_pin_i, byte_high_enable_n_i}),
    .adr_i(adr_i),
    .data_i(data_i),
    .pins_o(p)
  );

  // byte lane decode: returns {valid, be_high, be_low}
  function automatic logic [2:0] hp_decode(input logic a0, input logic byte_high_enable_n, input logic w);
    logic [2:0] r;
    r = 3'h0;
    if (!w) begin
      // narrow port: address bit 0 alone picks the lane
      if (a0) begin
        r = 3'h6;
      end else begin
        r = 3'h5;
      end
    end else begin
      case ({a0, byte_high_enable_n})
        2'b01: r = 3'h7;
        2'b00: r = 3'h5;
        2'b11: r = 3'h6;
        default: r = 3'h0;
      endcase
    end
    return r;
  endfunction

  // write is complete when the select-and-strobe pair goes away
  assign wr_act = p.cs & p.wr;
  assign rd_act = p.cs & p.rd;
  assign wr_end = wr_act_q & ~wr_act;
  assign rd_start = rd_act & ~rd_act_q;
  assign rd_end = rd_act_q & ~rd_act;
  assign rd_go = rd_act & (rd_start | rd_pend_q);
  // a read waiting behind a running write keeps busy up
  assign busy = (st_q == HP_WRITE) | (st_q == HP_READ) | rd_pend_q;

  assign {wvalid, wbe} = hp_decode(wadr_q[0], wbhe_q, wide);
  assign {rvalid, rbe} = hp_decode(p.adr[0], p.byte_high_enable_n, wide);

  // read, byte or word, at the exact address of a byte just written pays the collision delay
  assign coll_adr = lwadr_q == p.adr;
  assign coll = lw_q && coll_adr && lwbe_q != 2'b11;

  // read busy length; base time rounded down, extras rounded up
  always_comb begin
    rd_cyc = `HP_CNT_W'(rbe == 2'b11 ? `HP_RD_WORD_CYC : `HP_RD_BYTE_CYC);
    if (rd_dly) begin
      rd_cyc = rd_cyc + `HP_CNT_W'(`HP_RD_DLY_CYC);
    end
    if (coll) begin
      rd_cyc = rd_cyc + `HP_CNT_W'(`HP_COLL_CYC);
    end
  end

  // latch write address, enable and data while the strobe is active
  always_comb begin
    wadr_d = wadr_q;
    wdat_d = wdat_q;
    wbhe_d = wbhe_q;
    if (wr_act) begin
      wadr_d = p.adr;
      wdat_d = p.data;
      wbhe_d = p.byte_high_enable_n;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wadr_q <= 16'h0000;
      wdat_q <= 16'h0000;
      wbhe_q <= 1'b0;
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else if (clk_en_i) begin
      wadr_q <= wadr_d;
      wdat_q <= wdat_d;
      wbhe_q <= wbhe_d;
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  // access sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_pend_d = rd_pend_q;
    radr_d = radr_q;
    rbhe_d = rbhe_q;
    lwadr_d = lwadr_q;
    lwbe_d = lwbe_q;
    lw_d = lw_q;
    rdata_d = rdata_q;
    mem_d = mem_q;
    mem_d.req = 1'b0;
    abort_d = 1'b0;
    err = 1'b0;
    if (wr_end) begin
      // released while busy: counted, yet the write still goes in
      if (busy) begin
        err = 1'b1;
      end
      if (!wvalid) begin
        err = 1'b1;
      end else begin
        st_d = HP_WRITE;
        cnt_d = `HP_CNT_W'(wbe == 2'b11 ? `HP_WR_WORD_CYC : `HP_WR_BYTE_CYC);
        mem_d = '{req: 1'b1, we: 1'b1, adr: wadr_q, be: wbe, wdata: wdat_q};
        // 8 bit odd byte sits on host lane 0, internal lane 1
        if (!wide) begin
          mem_d.wdata = {wdat_q[7:0], wdat_q[7:0]};
        end
        lwadr_d = wadr_q;
        lwbe_d = wbe;
        lw_d = 1'b1;
      end
    end else begin
      case (st_q)
        HP_IDLE, HP_HOLD: begin
          if (st_q == HP_HOLD && !rd_act) begin
            st_d = HP_IDLE;
          end
          if (rd_go || (st_q == HP_HOLD && rd_act && (p.adr != radr_q || p.byte_high_enable_n != rbhe_q))) begin
            rd_pend_d = 1'b0;
            radr_d = p.adr;
            rbhe_d = p.byte_high_enable_n;
            if (!rvalid) begin
              err = 1'b1;
              st_d = HP_HOLD;
            end else begin
              st_d = HP_READ;
              cnt_d = rd_cyc;
              mem_d = '{req: 1'b1, we: 1'b0, adr: p.adr, be: rbe, wdata: 16'h0000};
              lw_d = 1'b0;
            end
          end
        end
        HP_WRITE: begin
          if (rd_start) begin
            rd_pend_d = 1'b1;
          end
          if (rd_end && rd_pend_q) begin
            err = 1'b1;
            rd_pend_d = 1'b0;
          end
          if (cnt_q <= `HP_CNT_W'(1)) begin
            st_d = HP_IDLE;
          end else begin
            cnt_d = cnt_q - `HP_CNT_W'(1);
          end
        end
        HP_READ: begin
          if (rd_end) begin
            err = 1'b1;
            abort_d = 1'b1;
            st_d = HP_IDLE;
          end else if (cnt_q <= `HP_CNT_W'(1)) begin
            st_d = HP_HOLD;
            rdata_d = mem_rdata_i;
            if (!wide && radr_q[0]) begin
              rdata_d = {8'h00, mem_rdata_i[15:8]};
            end
          end else begin
            cnt_d = cnt_q - `HP_CNT_W'(1);
          end
        end
        default: begin
          st_d = HP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= HP_IDLE;
      cnt_q <= '0;
      rd_pend_q <= 1'b0;
      radr_q <= 16'h0000;
      rbhe_q <= 1'b0;
      lwadr_q <= 16'h0000;
      lwbe_q <= 2'h0;
      lw_q <= 1'b0;
      rdata_q <= 16'h0000;
      mem_q <= '0;
      abort_q <= 1'b0;
    end else if (clk_en_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_pend_q <= rd_pend_d;
      radr_q <= radr_d;
      rbhe_q <= rbhe_d;
      lwadr_q <= lwadr_d;
      lwbe_q <= lwbe_d;
      lw_q <= lw_d;
      rdata_q <= rdata_d;
      mem_q <= mem_d;
      abort_q <= abort_d;
    end
  end

  hp_err_cnt u_err (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clk_en_i(clk_en_i),
    .inc_i(err & clk_en_i),
    .clr_i(err_clr_i & clk_en_i),
    .cnt_o(err_cnt_o)
  );

  // pin drivers; busy and data oe follow the registered pins, so their release lags one cycle
  assign busy_oe_o = p.cs;
  assign busy_o = busy ~^ cfg_i.b150[`HP_POL_BUSY];
  // data driven only while the sequencer holds, after a finished read or a rejected one
  always_comb begin
    data_oe_o = 2'b00;
    if (rd_act && st_q == HP_HOLD) begin
      data_oe_o[0] = 1'b1;
      data_oe_o[1] = wide;
    end
  end
  assign data_o = rdata_q;
  assign irq_o = irq_req_i ~^ cfg_i.b150[`HP_POL_IRQ];
  assign irq_oe_o = en;
  assign cfg_loaded_o = 1'b1;
  assign cfg_loaded_oe_o = en;
  assign mem_o = mem_q;
  assign abort_o = abort_q;

endmodule // hp_async_port

/* tb/hp_mem_model.sv */
// internal memory behind the host port, byte wide, answers reads one clock after the request
// assumes one request pulse per access and lanes as given by mem_i.be
`timescale 1ns/1ps
module hp_mem_model
  import hp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire hp_mem_t mem_i,
  output logic [15:0] rdata_o
);
  logic [7:0] mem_q [0:65535];
  logic [15:0] ev;
  always @(posedge sys_clk_i) begin
    ev = {mem_i.adr[15:1], 1'b0};
    if (mem_i.req && mem_i.we) begin
      if (mem_i.be[0]) mem_q[ev] <= mem_i.wdata[7:0];
      if (mem_i.be[1]) mem_q[ev + 16'h0001] <= mem_i.wdata[15:8];
    end
    // read data stays until the next read, the port samples it late
    if (mem_i.req && !mem_i.we) rdata_o <= {mem_q[ev + 16'h0001], mem_q[ev]};
  end
endmodule // hp_mem_model

/* tb/hp_port_chk.sv */
// port checker, sees only the host port top module's ports
// assumes default active-low polarity; other polarities are not judged
`timescale 1ns/1ps
module hp_port_chk
  import hp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] port_type_i,
  input wire hp_cfg_t cfg_i,
  input wire logic cs_pin_i,
  input wire logic rd_pin_i,
  input wire logic [15:0] data_o,
  input wire logic [1:0] data_oe_o,
  input wire logic busy_o,
  input wire logic busy_oe_o,
  input wire hp_mem_t mem_o,
  input wire logic [7:0] err_cnt_o
);
  logic ok;
  assign ok = cfg_i.b150 == 8'h00 && (port_type_i == 8'h08 || port_type_i == 8'h09);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  AST_BUSY_OE: assert property (ok && $past(ok) && !$past(srst_i) |->
    busy_oe_o == !$past(cs_pin_i)) else $error("busy driver wrong");
  AST_DATA_OE: assert property (ok && data_oe_o != 2'b00 |->
    !$past(cs_pin_i) && !$past(rd_pin_i)) else $error("data driven outside read");
  AST_HOLD: assert property (data_oe_o != 2'b00 && $past(data_oe_o) != 2'b00 |->
    $stable(data_o)) else $error("read data moved");
  AST_WORD_EVEN: assert property (mem_o.req && mem_o.be == 2'b11 |->
    !mem_o.adr[0]) else $error("word access odd");
  AST_LANE: assert property (mem_o.req && mem_o.be != 2'b11 |->
    mem_o.be == {mem_o.adr[0], !mem_o.adr[0]}) else $error("byte lane wrong");
  AST_NARROW: assert property (mem_o.req && port_type_i == 8'h09 |->
    mem_o.be != 2'b11) else $error("word in 8 bit mode");
  AST_WR_BYTE: assert property (ok && mem_o.req && mem_o.we && mem_o.be != 2'b11 |->
    !busy_o [*8]) else $error("byte write busy short");
  AST_WR_WORD: assert property (ok && mem_o.req && mem_o.we && mem_o.be == 2'b11 |->
    !busy_o [*3] ##1 !busy_o [*8]) else $error("word write busy short");
  AST_ERR_STEP: assert property (err_cnt_o != $past(err_cnt_o) |->
    err_cnt_o == $past(err_cnt_o) + 8'h01 || err_cnt_o <= 8'h01) else $error("error count jump");
endmodule // hp_port_chk
bind hp_async_port hp_port_chk u_chk (.sys_clk_i, .srst_i, .port_type_i, .cfg_i,
  .cs_pin_i, .rd_pin_i, .data_o, .data_oe_o, .busy_o, .busy_oe_o, .mem_o, .err_cnt_o);

/* tb/hp_async_port_bench.sv */
// bench for the async host port: host tasks drive the pins, memory model behind
// assumes default active-low pins, 40 MHz clock, bench acts as the host
`timescale 1ns/1ps
module hp_async_port_bench import hp_pkg::*;;
  logic sys_clk_i, srst_i, cfg_done_i, cs_pin_i, rd_pin_i, wr_pin_i;
  logic byte_high_enable_n_i, irq_req_i, err_clr_i, busy_o, busy_oe_o, irq_o, abort_o;
  logic cfg_loaded_o, cfg_loaded_oe_o, irq_oe_o;
  logic [7:0] port_type_i, err_cnt_o;
  logic [15:0] adr_i, data_i, wdat, data_o, mem_rdata_i;
  logic [1:0] data_oe_o;
  hp_cfg_t cfg_i;
  hp_mem_t mem_o;
  int err_count, checks_done, cycles, reqs, aborts, r0;
  // host lanes read back what the port drives
  assign data_i = {data_oe_o[1] ? data_o[15:8] : wdat[15:8], data_oe_o[0] ? data_o[7:0] : wdat[7:0]};
  hp_async_port u_dut (.sys_clk_i, .srst_i, .clk_en_i(1'b1), .port_type_i, .cfg_i,
    .cfg_done_i, .cs_pin_i, .rd_pin_i, .wr_pin_i, .byte_high_enable_n_i, .adr_i,
    .data_i, .data_o, .data_oe_o, .busy_o, .busy_oe_o, .irq_req_i, .irq_o, .irq_oe_o,
    .cfg_loaded_o, .cfg_loaded_oe_o, .mem_o, .mem_rdata_i, .abort_o, .err_clr_i, .err_cnt_o);
  hp_mem_model u_mem (.sys_clk_i, .mem_i(mem_o), .rdata_o(mem_rdata_i));
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    reqs += int'(mem_o.req === 1'b1);
    aborts += int'(abort_o === 1'b1);
    if (cycles == 5000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // busy cycles counted from first active sample, bounded both ways
  task automatic busy_len(output int n);
    int t;
    t = 0;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      t++;
    end while (busy_o !== 1'b0 && t < 40);
    while (busy_o === 1'b0 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask
  task automatic raw(input logic [15:0] a, input logic b, input logic w,
                     input logic [15:0] d, input int n);
    @(posedge sys_clk_i);
    cs_pin_i <= 1'b0;
    adr_i <= a;
    byte_high_enable_n_i <= b;
    wdat <= d;
    if (w) wr_pin_i <= 1'b0;
    else rd_pin_i <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    cs_pin_i <= 1'b1;
    wr_pin_i <= 1'b1;
    rd_pin_i <= 1'b1;
  endtask
  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d, input int e);
    int n;
    @(posedge sys_clk_i);
    cs_pin_i <= 1'b0;
    adr_i <= a;
    byte_high_enable_n_i <= b;
    wdat <= d;
    wr_pin_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    wr_pin_i <= 1'b1;
    busy_len(n);
    chk(n, e);
    @(posedge sys_clk_i);
    cs_pin_i <= 1'b1;
  endtask
  task automatic rd(input logic [15:0] a, input logic b, input int e,
                    input logic [15:0] d, input logic [15:0] m);
    int n;
    @(posedge sys_clk_i);
    cs_pin_i <= 1'b0;
    rd_pin_i <= 1'b0;
    adr_i <= a;
    byte_high_enable_n_i <= b;
    busy_len(n);
    chk(n, e);
    chk(|data_oe_o, 1'b1);
    chk(data_o & m, d & m);
    @(posedge sys_clk_i);
    cs_pin_i <= 1'b1;
    rd_pin_i <= 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk(busy_oe_o, 1'b0);
    chk(data_oe_o, 2'b00);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    srst_i = 1'b1;
    {cs_pin_i, rd_pin_i, wr_pin_i, byte_high_enable_n_i, irq_req_i} = 5'h1f;
    {cfg_done_i, err_clr_i} = 2'h0;
    port_type_i = 8'h08;
    cfg_i = '0;
    adr_i = 16'h0000;
    wdat = 16'h0000;
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(busy_oe_o, 1'b0);
    chk(err_cnt_o, 8'h00);
    chk(cfg_loaded_oe_o, 1'b0);
    @(posedge sys_clk_i);
    cfg_done_i <= 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk({cfg_loaded_oe_o, cfg_loaded_o, irq_o, irq_oe_o}, 4'hd);
    wr(16'h0100, 1'b0, 16'h1234, 11);
    wr(16'h0103, 1'b0, 16'hab00, 8);
    wr(16'h0102, 1'b1, 16'h00cd, 8);
    rd(16'h0102, 1'b0, 13, 16'habcd, 16'hffff);
    rd(16'h0100, 1'b1, 9, 16'h0034, 16'h00ff);
    wr(16'h0101, 1'b0, 16'h5600, 8);
    rd(16'h0101, 1'b0, 10, 16'h5600, 16'hff00);
    @(posedge sys_clk_i);
    cfg_i.b152 <= 8'h01;
    rd(16'h0100, 1'b0, 13, 16'h5634, 16'hffff);
    @(posedge sys_clk_i);
    cfg_i <= '0;
    r0 = reqs;
    raw(16'h0101, 1'b1, 1'b0, 16'h0000, 6);
    chk(reqs, r0);
    raw(16'h0100, 1'b0, 1'b0, 16'h0000, 3);
    repeat (20) @(posedge sys_clk_i);
    chk(aborts, 1);
    raw(16'h0104, 1'b1, 1'b1, 16'h00aa, 2);
    raw(16'h0104, 1'b1, 1'b1, 16'h00bb, 2);
    repeat (25) @(posedge sys_clk_i);
    rd(16'h0104, 1'b1, 10, 16'h00bb, 16'h00ff);
    chk(err_cnt_o, 8'h03);
    @(posedge sys_clk_i);
    err_clr_i <= 1'b1;
    @(posedge sys_clk_i);
    err_clr_i <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(err_cnt_o, 8'h00);
    @(posedge sys_clk_i);
    cfg_i.b150 <= 8'h30;
    repeat (2) @(negedge sys_clk_i);
    chk({busy_o, irq_o}, 2'b01);
    @(posedge sys_clk_i);
    cfg_i.b150 <= 8'h00;
    // 8 bit host keeps the unused enable and upper lanes driven
    port_type_i <= 8'h09;
    wr(16'h0201, 1'b1, 16'h0077, 8);
    wr(16'h0200, 1'b1, 16'h0011, 8);
    rd(16'h0201, 1'b1, 9, 16'h0077, 16'h00ff);
    rd(16'h0200, 1'b1, 9, 16'h0011, 16'h00ff);
    @(posedge sys_clk_i);
    port_type_i <= 8'h00;
    r0 = reqs;
    raw(16'h0100, 1'b0, 1'b1, 16'h0000, 4);
    repeat (4) @(negedge sys_clk_i);
    chk(reqs, r0);
    chk({cfg_loaded_oe_o, irq_oe_o}, 2'b00);
    give_verdict;
  end
endmodule // hp_async_port_bench
